// ### logic/qpd_pkg.sv
// Constants for the quad wiper serial command decoder.
// Assumes one system clock and one serial link clock from the host.
// How it works
// [R1] Word: command nibble, address nibble, data byte
// [R2] Wipers take six bits, cells eight
// [R3] Command 0 changes no wiper, clears read power
// [R4] Command 1 restores wiper, sets read power
// [R5] Command 2 stores wiper into its cell
// [R6] Command 3 writes data byte to cell
// [R7] Wiper cells hold six meaningful bits
// [R8] Command 4 halves wiper, stops at zero
// [R9] Command 5 halves all wipers
// [R10] Commands 6, 7 decrement, saturate at zero
// [R11] Command 8 reloads all wipers from cells
// [R12] Command 9 reads cell next frame
// [R13] Command 10 reads wiper next frame
// [R14] Command 11 loads six data bits to wiper
// [R15] Command 12 doubles wiper, saturates full scale
// [R16] Command 13 doubles all wipers
// [R17] Commands 14, 15 increment, saturate at ones
// [R18] Serial out echoes last word or read data
// [R19] Execute only when chip select rises
// [R20] Step and shift commands ignore data byte
// [R21] Power-on preset loads wipers from cells
// [R22] Latched outputs hold stored level, default high
// [R23] Frames are whole multiples of sixteen bits
// [R24] Clockless select pulse repeats last command
// [R25] Output level cell reloaded on 1, 8
// [R26] Left shift: zero gives one, midscale full
// [R27] Cell bit 0 first output, bit 1 second
// [R28] Serial out released while chip select high
package qpd_pkg;
    localparam int WORD_W = 16;
    localparam int WIPER_W = 6;
    localparam int CELL_W = 8;
    localparam int NUM_CH = 4;
    localparam int NUM_CELLS = 16;
    localparam logic [3:0] BIT_LAST = 4'hf;
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_RESTORE = 4'h1;
    localparam logic [3:0] CMD_STORE = 4'h2;
    localparam logic [3:0] CMD_WRITE_CELL = 4'h3;
    localparam logic [3:0] CMD_SHR = 4'h4;
    localparam logic [3:0] CMD_SHR_ALL = 4'h5;
    localparam logic [3:0] CMD_DEC = 4'h6;
    localparam logic [3:0] CMD_DEC_ALL = 4'h7;
    localparam logic [3:0] CMD_RELOAD = 4'h8;
    localparam logic [3:0] CMD_READ_CELL = 4'h9;
    localparam logic [3:0] CMD_READ_WIPER = 4'ha;
    localparam logic [3:0] CMD_WRITE_WIPER = 4'hb;
    localparam logic [3:0] CMD_SHL = 4'hc;
    localparam logic [3:0] CMD_SHL_ALL = 4'hd;
    localparam logic [3:0] CMD_INC = 4'he;
    localparam logic [3:0] CMD_INC_ALL = 4'hf;
    localparam logic [3:0] CELL_OUTS = 4'h4;
    localparam logic [5:0] WIPER_FULL = 6'h3f;
    localparam logic [5:0] WIPER_MID = 6'h20;
    localparam logic [5:0] WIPER_ONE = 6'h01;
    localparam logic [7:0] CELL_WIPER_RST = 8'h20;
    localparam logic [7:0] CELL_OUTS_RST = 8'hff;
    localparam logic [7:0] CELL_USER_RST = 8'hff;
    localparam int OUT1_BIT = 0;
    localparam int OUT2_BIT = 1;
    typedef enum logic [1:0] {
        QPD_PRESET = 2'b00,
        QPD_IDLE = 2'b01,
        QPD_EXEC = 2'b11
    } qpd_state_e;
endpackage : qpd_pkg

// ### logic/qpd_decoder.sv
// Serial command decoder, wiper registers and nonvolatile cells.
// Assumes a serial host in clock mode 0, select low for whole words,
// and a system clock at least four times the serial clock.
`timescale 1ns/1ps
`default_nettype none
module qpd_decoder (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo_o,
    output logic sdo_oe,
    output logic [qpd_pkg::WIPER_W-1:0] wiper_ch0,
    output logic [qpd_pkg::WIPER_W-1:0] wiper_ch1,
    output logic [qpd_pkg::WIPER_W-1:0] wiper_ch2,
    output logic [qpd_pkg::WIPER_W-1:0] wiper_ch3,
    output logic latched_output_one,
    output logic latched_output_two,
    output logic read_power
);
    import qpd_pkg::*;

    function automatic logic [5:0] shl_sat(input logic [5:0] v);
        if (v == 6'h00) begin
            return WIPER_ONE; // R26
        end else if (v >= WIPER_MID) begin
            return WIPER_FULL; // R26
        end
        return {v[4:0], 1'b0}; // R15
    endfunction : shl_sat

    function automatic logic [5:0] inc_sat(input logic [5:0] v);
        return (v == WIPER_FULL) ? v : v + 6'h01; // R17
    endfunction : inc_sat

    function automatic logic [5:0] dec_sat(input logic [5:0] v);
        return (v == 6'h00) ? v : v - 6'h01; // R10
    endfunction : dec_sat

    // Link side, serial clock domain
    logic [3:0] bit_cnt_q;
    logic [WORD_W-1:0] shreg_q;
    logic [WORD_W-1:0] frame_word_q;
    logic word_seen_q;
    logic clk_seen_q;

    // Counter and seen flags end with the frame's own select
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_q <= 4'h0; // R23
            word_seen_q <= 1'b0;
            clk_seen_q <= 1'b0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1; // R23
            clk_seen_q <= 1'b1;
            if (bit_cnt_q == BIT_LAST) begin
                word_seen_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge sclk) begin
        shreg_q <= {shreg_q[WORD_W-2:0], sdi}; // R18
        if (bit_cnt_q == BIT_LAST) begin
            frame_word_q <= {shreg_q[WORD_W-2:0], sdi}; // R1
        end
    end

    // Crossings into the system clock
    logic [1:0] cs_s_q;
    logic [1:0] word_s_q;
    logic [1:0] clk_s_q;
    logic [1:0] sclk_s_q;
    logic [1:0] echo_s_q;
    logic cs_d1_q;
    logic sclk_d1_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cs_s_q <= 2'b11;
            word_s_q <= 2'b00;
            clk_s_q <= 2'b00;
            sclk_s_q <= 2'b00;
            echo_s_q <= 2'b11;
            cs_d1_q <= 1'b1;
            sclk_d1_q <= 1'b0;
        end else begin
            cs_s_q <= {cs_s_q[0], cs_n};
            word_s_q <= {word_s_q[0], word_seen_q};
            clk_s_q <= {clk_s_q[0], clk_seen_q};
            sclk_s_q <= {sclk_s_q[0], sclk};
            echo_s_q <= {echo_s_q[0], shreg_q[WORD_W-1]};
            cs_d1_q <= cs_s_q[1];
            sclk_d1_q <= sclk_s_q[1];
        end
    end

    logic cs_rise;
    logic cs_fall;
    logic sclk_fall;
    assign cs_rise = cs_s_q[1] && !cs_d1_q;
    assign cs_fall = !cs_s_q[1] && cs_d1_q;
    assign sclk_fall = !sclk_s_q[1] && sclk_d1_q && !cs_s_q[1];

    // Frame tracking and command capture
    logic got_word_q;
    logic got_clk_q;
    logic have_cmd_q;
    logic [WORD_W-1:0] cmd_word_q;
    logic start_exec;

    always_ff @(posedge mclk) begin
        if (sys_rst || cs_fall) begin
            got_word_q <= 1'b0;
            got_clk_q <= 1'b0;
        end else begin
            got_word_q <= got_word_q || word_s_q[1];
            got_clk_q <= got_clk_q || clk_s_q[1];
        end
    end

    // Word stays still once select is high and the clock has stopped
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            have_cmd_q <= 1'b0;
            cmd_word_q <= '0;
        end else if (cs_rise && got_word_q) begin
            have_cmd_q <= 1'b1; // R24
            cmd_word_q <= frame_word_q; // R19
        end
    end

    // Clockless pulse repeats, never before a first command
    assign start_exec = cs_rise &&
        (got_word_q || (!got_clk_q && have_cmd_q)); // R24

    logic [3:0] cmd;
    logic [3:0] addr;
    logic [1:0] ch;
    logic [7:0] data;
    assign cmd = cmd_word_q[15:12]; // R1
    assign addr = cmd_word_q[11:8];
    assign ch = cmd_word_q[9:8];
    assign data = cmd_word_q[7:0];

    // Sequencer
    qpd_state_e state_q;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= QPD_PRESET; // R21
        end else begin
            unique case (state_q)
                QPD_PRESET: state_q <= QPD_IDLE;
                QPD_IDLE: begin
                    if (start_exec) begin
                        state_q <= QPD_EXEC; // R19
                    end
                end
                QPD_EXEC: state_q <= QPD_IDLE;
                default: state_q <= QPD_PRESET;
            endcase
        end
    end

    logic exec;
    logic preset;
    assign exec = (state_q == QPD_EXEC);
    assign preset = (state_q == QPD_PRESET);

    // Nonvolatile cells, factory defaults on reset
    logic [WIPER_W-1:0] wip_q [NUM_CH];
    logic [CELL_W-1:0] cell_q [NUM_CELLS];
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_CELLS; i++) begin
                if (i < NUM_CH) begin
                    cell_q[i] <= CELL_WIPER_RST;
                end else if (i == int'(CELL_OUTS)) begin
                    cell_q[i] <= CELL_OUTS_RST;
                end else begin
                    cell_q[i] <= CELL_USER_RST;
                end
            end
        end else if (exec && cmd == CMD_STORE) begin
            cell_q[{2'b00, ch}] <= {2'b00, wip_q[ch]}; // R5
        end else if (exec && cmd == CMD_WRITE_CELL) begin
            cell_q[addr] <= data; // R6 R2
        end
    end

    // Wiper registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                wip_q[i] <= CELL_WIPER_RST[5:0];
            end
        end else if (preset) begin
            for (int i = 0; i < NUM_CH; i++) begin
                wip_q[i] <= cell_q[i][5:0]; // R21 R7
            end
        end else if (exec) begin
            unique case (cmd)
                CMD_RESTORE: wip_q[ch] <= cell_q[{2'b00, ch}][5:0]; // R4
                CMD_SHR: wip_q[ch] <= wip_q[ch] >> 1; // R8 R20
                CMD_DEC: wip_q[ch] <= dec_sat(wip_q[ch]); // R10 R20
                CMD_WRITE_WIPER: wip_q[ch] <= data[5:0]; // R14 R2
                CMD_SHL: wip_q[ch] <= shl_sat(wip_q[ch]); // R15 R20
                CMD_INC: wip_q[ch] <= inc_sat(wip_q[ch]); // R17 R20
                CMD_SHR_ALL, CMD_DEC_ALL, CMD_RELOAD, CMD_SHL_ALL,
                CMD_INC_ALL: begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        unique case (cmd)
                            CMD_SHR_ALL: wip_q[i] <= wip_q[i] >> 1; // R9
                            CMD_DEC_ALL: wip_q[i] <= dec_sat(wip_q[i]);
                            CMD_RELOAD: wip_q[i] <= cell_q[i][5:0]; // R11
                            CMD_SHL_ALL: wip_q[i] <= shl_sat(wip_q[i]); // R16
                            default: wip_q[i] <= inc_sat(wip_q[i]);
                        endcase
                    end
                end
                default: ; // R3
            endcase
        end
    end

    assign wiper_ch0 = wip_q[0];
    assign wiper_ch1 = wip_q[1];
    assign wiper_ch2 = wip_q[2];
    assign wiper_ch3 = wip_q[3];

    // Latched outputs and read power state
    logic out1_q;
    logic out2_q;
    logic rd_pwr_q;
    logic outs_load;
    assign outs_load = preset ||
        (exec && (cmd == CMD_RESTORE || cmd == CMD_RELOAD)); // R25

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            out1_q <= CELL_OUTS_RST[OUT1_BIT]; // R22
            out2_q <= CELL_OUTS_RST[OUT2_BIT]; // R22
        end else if (outs_load) begin
            out1_q <= cell_q[CELL_OUTS][OUT1_BIT]; // R27
            out2_q <= cell_q[CELL_OUTS][OUT2_BIT]; // R27
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rd_pwr_q <= 1'b0;
        end else if (exec && cmd == CMD_RESTORE) begin
            rd_pwr_q <= 1'b1; // R4
        end else if (exec && cmd == CMD_NOP) begin
            rd_pwr_q <= 1'b0; // R4
        end
    end

    assign latched_output_one = out1_q;
    assign latched_output_two = out2_q;
    assign read_power = rd_pwr_q;

    // Readback shifter for the frame after a read command
    logic rd_sel_q;
    logic [WORD_W-1:0] rd_sh_q;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rd_sel_q <= 1'b0;
            rd_sh_q <= '0;
        end else if (exec && cmd == CMD_READ_CELL) begin
            rd_sel_q <= 1'b1;
            rd_sh_q <= {cmd, addr, cell_q[addr]}; // R12
        end else if (exec && cmd == CMD_READ_WIPER) begin
            rd_sel_q <= 1'b1;
            rd_sh_q <= {cmd, addr, 2'b00, wip_q[ch]}; // R13
        end else if (cs_rise) begin
            rd_sel_q <= 1'b0; // R18
        end else if (sclk_fall) begin
            rd_sh_q <= {rd_sh_q[WORD_W-2:0], 1'b0};
        end
    end

    // Open-drain serial out, pulls low only for a zero bit
    logic sdo_oe_q;
    logic sdo_bit;
    assign sdo_bit = rd_sel_q ? rd_sh_q[WORD_W-1] : echo_s_q[1]; // R18
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sdo_oe_q <= 1'b0;
        end else begin
            sdo_oe_q <= !cs_s_q[1] && !sdo_bit; // R28
        end
    end

    logic sdo_o_q;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sdo_o_q <= 1'b0;
        end else begin
            sdo_o_q <= 1'b0;
        end
    end
    assign sdo_o = sdo_o_q;
    assign sdo_oe = sdo_oe_q;

    // Checks
    chk_nop_holds: assert property ( // R3
        @(posedge mclk) disable iff (sys_rst)
        exec && cmd == CMD_NOP |=> $stable(wip_q[0]) && $stable(wip_q[3]))
        else $error("nop changed a wiper");
    chk_nop_power: assert property ( // R4
        @(posedge mclk) disable iff (sys_rst)
        exec && cmd == CMD_NOP |=> !read_power)
        else $error("nop left read power on");
    chk_restore_copy: assert property ( // R4
        @(posedge mclk) disable iff (sys_rst)
        exec && cmd == CMD_RESTORE
        |=> wip_q[$past(ch)] == cell_q[$past(ch)][5:0] && read_power)
        else $error("restore did not load wiper");
    chk_dec_floor: assert property ( // R10
        @(posedge mclk) disable iff (sys_rst)
        exec && cmd == CMD_DEC && wip_q[ch] == 6'h00
        |=> wip_q[$past(ch)] == 6'h00)
        else $error("decrement went below zero");
    chk_inc_ceiling: assert property ( // R17
        @(posedge mclk) disable iff (sys_rst)
        exec && cmd == CMD_INC_ALL && wip_q[1] == WIPER_FULL
        |=> wip_q[1] == WIPER_FULL)
        else $error("increment passed full scale");
    chk_shl_zero: assert property ( // R26
        @(posedge mclk) disable iff (sys_rst)
        exec && cmd == CMD_SHL && wip_q[ch] == 6'h00
        |=> wip_q[$past(ch)] == WIPER_ONE)
        else $error("left shift of zero not one");
    chk_wiper_write: assert property ( // R14
        @(posedge mclk) disable iff (sys_rst)
        exec && cmd == CMD_WRITE_WIPER
        |=> wip_q[$past(ch)] == $past(data[5:0]))
        else $error("wiper write lost");
    chk_store_copy: assert property ( // R5
        @(posedge mclk) disable iff (sys_rst)
        exec && cmd == CMD_STORE
        |=> cell_q[$past(ch)] == {2'b00, $past(wip_q[ch])})
        else $error("store did not copy wiper");
    chk_cell_write: assert property ( // R6
        @(posedge mclk) disable iff (sys_rst)
        exec && cmd == CMD_WRITE_CELL
        |=> cell_q[$past(addr)] == $past(data))
        else $error("cell write lost");
    chk_read_load: assert property ( // R12
        @(posedge mclk) disable iff (sys_rst)
        exec && cmd == CMD_READ_CELL
        |=> rd_sel_q &&
        rd_sh_q == {CMD_READ_CELL, $past(addr), $past(cell_q[addr])})
        else $error("cell read not loaded");
    chk_preset_load: assert property ( // R21
        @(posedge mclk) disable iff (sys_rst)
        preset |=> wip_q[2] == cell_q[2][5:0] && state_q == QPD_IDLE)
        else $error("preset did not load wipers");
    chk_outs_default: assert property ( // R22
        @(posedge mclk)
        sys_rst |=> latched_output_one && latched_output_two)
        else $error("latched outputs not high after reset");
    chk_outs_reload: assert property ( // R25
        @(posedge mclk) disable iff (sys_rst)
        exec && cmd == CMD_RELOAD
        |=> latched_output_one == $past(cell_q[CELL_OUTS][OUT1_BIT])
        && latched_output_two == $past(cell_q[CELL_OUTS][OUT2_BIT]))
        else $error("latched outputs not reloaded");
    chk_sdo_release: assert property ( // R28
        @(posedge mclk) disable iff (sys_rst)
        cs_s_q[1] |=> !sdo_oe)
        else $error("serial out driven while deselected");
    chk_exec_on_rise: assert property ( // R19
        @(posedge mclk) disable iff (sys_rst)
        state_q == QPD_IDLE && !cs_rise |=> !exec)
        else $error("command ran without select rising");
    cov_partial: cover property (@(posedge mclk) disable iff (sys_rst)
        cs_rise && got_clk_q && !got_word_q);
    cov_repeat: cover property (@(posedge mclk) disable iff (sys_rst)
        cs_rise && !got_clk_q && have_cmd_q);
    cov_read_cell: cover property (@(posedge mclk) disable iff (sys_rst)
        exec && cmd == CMD_READ_CELL ##[1:1000] sclk_fall && rd_sel_q);
    cov_shl_all: cover property (@(posedge mclk) disable iff (sys_rst)
        exec && cmd == CMD_SHL_ALL);
    cov_restore: cover property (@(posedge mclk) disable iff (sys_rst)
        exec && cmd == CMD_RESTORE);
endmodule : qpd_decoder
`default_nettype wire

// ### test/qpd_host.sv
// Serial host model for the quad wiper decoder link.
// Assumes mode 0 and an open-drain data line pulled up by the bench.
`timescale 1ns/1ps
`default_nettype none
module qpd_host (
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo_line
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // Sends the low n bits of w, MSB first; rx keeps the last 16 seen
    task frame(input logic [31:0] w, input int n, output logic [15:0] rx);
        int i;
        cs_n = 1'b0;
        for (i = n - 1; i >= 0; i--) begin
            sdi = w[i];
            #80;
            rx = {rx[14:0], sdo_line};
            sclk = 1'b1;
            #80;
            sclk = 1'b0;
        end
        sdi = ~sdi;
        #80;
        cs_n = 1'b1;
        #200;
    endtask : frame

    // Select pulse with the link clock still
    task pulse();
        cs_n = 1'b0;
        #300;
        cs_n = 1'b1;
        #200;
    endtask : pulse
endmodule : qpd_host
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the quad wiper serial command decoder.
// Assumes the host model drives the link and the data line is pulled up.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import qpd_pkg::*;
    logic mclk;
    logic sys_rst;
    wire sclk;
    wire cs_n;
    wire sdi;
    wire sdo_line;
    logic sdo_o;
    logic sdo_oe;
    logic [WIPER_W-1:0] w0;
    logic [WIPER_W-1:0] w1;
    logic [WIPER_W-1:0] w2;
    logic [WIPER_W-1:0] w3;
    logic out1;
    logic out2;
    logic rp;
    logic [15:0] rx;
    int miscompares;
    int compares;
    int cycles;

    assign sdo_line = sdo_oe ? sdo_o : 1'b1;

    qpd_decoder uut (.mclk(mclk), .sys_rst(sys_rst), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .wiper_ch0(w0), .wiper_ch1(w1), .wiper_ch2(w2), .wiper_ch3(w3),
        .latched_output_one(out1), .latched_output_two(out2),
        .read_power(rp));

    qpd_host host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo_line(sdo_line));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            finish_test();
        end
    end

    task finish_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task chk(input string what, input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", what, e, g);
        end
    endtask : chk

    task chk_w(input logic [5:0] e0, e1, e2, e3);
        chk("wipers", {e0, e1, e2, e3}, {w0, w1, w2, w3});
    endtask : chk_w

    task send(input logic [15:0] w);
        host.frame({16'h0000, w}, 16, rx);
    endtask : send

    task t_reset();
        @(posedge mclk);
        #1 sys_rst = 1'b1;
        repeat (20) @(posedge mclk);
        #1 sys_rst = 1'b0;
        repeat (5) @(posedge mclk);
        chk_w(6'h20, 6'h20, 6'h20, 6'h20);
        chk("outs", 2'b11, {out1, out2});
        chk("read_power", 1'b0, rp);
        chk("sdo idle", 1'b1, sdo_line);
        host.pulse();
        chk_w(6'h20, 6'h20, 6'h20, 6'h20);
        $display("test reset done");
    endtask : t_reset

    task t_write();
        send(16'hb0ff);
        send(16'hb1d5);
        send(16'hb22a);
        send(16'hb3c0);
        chk("echo", 16'hb22a, rx);
        chk_w(6'h3f, 6'h15, 6'h2a, 6'h00);
        send(16'h0fff);
        chk_w(6'h3f, 6'h15, 6'h2a, 6'h00);
        chk("echo", 16'hb3c0, rx);
        $display("test write done");
    endtask : t_write

    task t_step();
        send(16'he0aa);
        send(16'h6300);
        send(16'he100);
        send(16'h6200);
        chk_w(6'h3f, 6'h16, 6'h29, 6'h00);
        send(16'hf000);
        chk_w(6'h3f, 6'h17, 6'h2a, 6'h01);
        send(16'h7000);
        chk_w(6'h3e, 6'h16, 6'h29, 6'h00);
        $display("test step done");
    endtask : t_step

    task t_shift();
        send(16'hc3ff);
        send(16'hc200);
        send(16'hc100);
        send(16'h40ff);
        chk_w(6'h1f, 6'h2c, 6'h3f, 6'h01);
        send(16'hd000);
        chk_w(6'h3e, 6'h3f, 6'h3f, 6'h02);
        send(16'h5000);
        chk_w(6'h1f, 6'h1f, 6'h1f, 6'h01);
        $display("test shift done");
    endtask : t_shift

    task t_nvm();
        send(16'h2300);
        send(16'hb33f);
        send(16'h1300);
        chk_w(6'h1f, 6'h1f, 6'h1f, 6'h01);
        chk("read_power", 1'b1, rp);
        send(16'h0000);
        chk("read_power", 1'b0, rp);
        send(16'h3402);
        send(16'h30ff);
        chk_w(6'h1f, 6'h1f, 6'h1f, 6'h01);
        send(16'h8000);
        chk_w(6'h3f, 6'h20, 6'h20, 6'h01);
        chk("outs", 2'b01, {out1, out2});
        $display("test nvm done");
    endtask : t_nvm

    task t_read();
        send(16'h35a5);
        send(16'h95ff);
        send(16'h0000);
        chk("cell read", 16'h95a5, rx);
        send(16'h9000);
        send(16'h0000);
        chk("cell read", 16'h90ff, rx);
        send(16'ha200);
        send(16'h0000);
        chk("wiper read", 16'ha220, rx);
        send(16'h0000);
        chk("echo", 16'h0000, rx);
        chk("sdo idle", 1'b1, sdo_line);
        $display("test read done");
    endtask : t_read

    task t_frame();
        host.frame(32'h000000b1, 8, rx);
        chk_w(6'h3f, 6'h20, 6'h20, 6'h01);
        host.frame(32'hb12ab205, 32, rx);
        chk_w(6'h3f, 6'h20, 6'h05, 6'h01);
        send(16'he100);
        host.pulse();
        chk_w(6'h3f, 6'h22, 6'h05, 6'h01);
        $display("test frame done");
    endtask : t_frame

    initial begin
        sys_rst = 1'b1;
        miscompares = 0;
        compares = 0;
        cycles = 0;
        t_reset();
        t_write();
        t_step();
        t_shift();
        t_nvm();
        t_read();
        t_frame();
        t_reset();
        finish_test();
    end
endmodule : tb
`default_nettype wire
